// ### hw/ppl_pkg.sv
// package: register map, field layouts, timing constants and carrier types
`default_nettype none
package ppl_pkg;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_WAKE_INT = 8'h08;
	localparam logic [7:0] REG_CABLE = 8'h0C;
	localparam logic [7:0] REG_LED_MODE = 8'h10;
	localparam logic [7:0] REG_LED_BEHAV = 8'h14;
	localparam logic [7:0] REG_EEE_CTRL = 8'h18;
	localparam logic [7:0] REG_IRQ_STAT = 8'h1C;
	localparam logic [7:0] REG_IRQ_MASK = 8'h20;
	// control register fields
	localparam int CTRL_PD_BIT = 0;
	localparam int CTRL_EPM_BIT = 1;
	// cable result fields
	localparam int CABLE_FAULT_BIT = 8;
	localparam int CABLE_VALID_BIT = 9;
	localparam int CABLE_UNREL_BIT = 10;
	localparam logic [7:0] CABLE_MAX_M = 8'h78;
	// interrupt status bits
	localparam int IRQ_DIAG_BIT = 0;
	localparam int IRQ_APD_BIT = 1;
	localparam int IRQ_WAKE_BIT = 2;
	localparam int IRQ_BITS = 3;
	// reset values
	localparam logic [15:0] WAKE_INT_RST = 16'h03E8;
	localparam logic [15:0] LED_MODE_RST = 16'h4320;
	localparam logic [7:0] LED_BEHAV_RST = 8'h00;
	// timing: clock and millisecond tick
	localparam int CLK_PERIOD_NS = 25;
	localparam int MS_TIME_NS = 1000000;
	localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;
	// timing in milliseconds
	localparam logic [15:0] QUIET_MS = 16'h03E8;
	localparam logic [15:0] BURST_MS = 16'h0002;
	localparam logic [7:0] BLINK_HALF_MS = 8'h32;
	localparam logic [7:0] STRETCH_MS = 8'h64;
	// led modes
	localparam logic [3:0] LED_M_LINK_ANY = 4'h0;
	localparam logic [3:0] LED_M_LINK_1000 = 4'h1;
	localparam logic [3:0] LED_M_LINK_100 = 4'h2;
	localparam logic [3:0] LED_M_LINK_10 = 4'h3;
	localparam logic [3:0] LED_M_LINK_HI = 4'h4;
	// link speed codes
	localparam logic [1:0] SPD_10 = 2'h0;
	localparam logic [1:0] SPD_100 = 2'h1;
	localparam logic [1:0] SPD_1000 = 2'h2;
	// suspend states
	typedef enum logic [1:0] {
		SUSP_NORMAL = 2'h0,
		SUSP_ATTACH = 2'h1,
		SUSP_WAKE = 2'h2,
		SUSP_DEEPEST = 2'h3
	} ppl_susp_type;
	// enhanced power states, gray along active-sleep-burst
	typedef enum logic [1:0] {
		EPM_ACTIVE = 2'b00,
		EPM_SLEEP = 2'b01,
		EPM_BURST = 2'b11
	} ppl_epm_type;
	// diagnostic result from the cable tester
	typedef struct packed {
		logic done;
		logic terminated;
		logic fault;
		logic [7:0] dist_m;
	} ppl_diag_type;
	// link status from the pcs
	typedef struct packed {
		logic up;
		logic [1:0] speed;
		logic activity;
	} ppl_link_type;
	// nonvolatile led and power defaults, five entries
	typedef struct packed {
		logic load;
		logic [4:0][7:0] entry;
	} ppl_nv_type;
endpackage
`default_nettype wire

// ### hw/ppl_top.sv
// power management, cable length and status light logic of the copper phy
// How it works
// - terminated cable reports length in meters
// - fault reports distance to fault instead
// - lengths above 120 m flagged unreliable
// - power-down control bit powers phy down
// - no signal detect auto powers down
// - sleeping phy wakes periodically, sends pulse burst
// - writing enable one activates enhanced mode outside deepest suspend
// - enhanced mode works except deepest suspend
// - nonvolatile default enables enhanced mode in wake
// - four lights, each with own mode field
// - lights active low, invert field flips polarity
// - behaviour register selects blink or stretch
// - five nonvolatile entries load light configuration
// - mode 0: one without link, zero with
// - mode 0 blinks or stretches on activity
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`default_nettype none
module ppl_top
	import ppl_pkg::*;
#(
	parameter int MS_CYC = MS_CYCLES,
	parameter int LEDS = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// media side and phy core status
	input wire logic signal_detect_i,
	input wire ppl_link_type link_i,
	input wire ppl_diag_type diag_i,
	input wire ppl_susp_type suspend_i,
	input wire ppl_nv_type nv_i,
	// power and wake outputs
	output logic phy_power_down_o,
	output logic flp_burst_o,
	// status lights and interrupt
	output logic [LEDS-1:0] status_light_outputs_o,
	output logic irq_o
);
	// software registers
	logic ctrl_pd_r; // standard power-down bit
	logic ctrl_epm_r; // enhanced power enable
	logic [15:0] wake_int_r; // wake interval in ms
	logic [15:0] led_mode_r; // four mode nibbles
	logic [7:0] led_behav_r; // stretch select and activity mask
	logic invert_r; // light polarity invert
	logic nv_wake_dflt_r; // nonvolatile enhanced default for wake state
	logic [IRQ_BITS-1:0] irq_stat_r; // sticky events
	logic [IRQ_BITS-1:0] irq_mask_r; // event enables
	logic [7:0] cable_m_r; // length or fault distance
	logic cable_fault_r; // result is a fault distance
	logic cable_valid_r; // a result is present
	logic cable_unrel_r; // result beyond reliable range
	// bus handshake
	logic ack_r;
	logic [31:0] rdat_r;
	logic wr_now;
	logic [31:0] wr_word;
	logic [31:0] lane_mask; // byte enables spread over their lanes
	logic [31:0] wr_merged; // write data merged into the register word
	logic [IRQ_BITS-1:0] irq_clr; // write-one clear of sticky events
	logic [IRQ_BITS-1:0] irq_set; // events seen this cycle
	// synchroniser and power machine
	logic sd_meta_r;
	logic sd_r;
	ppl_epm_type epm_r;
	logic [15:0] ms_cnt_r;
	logic [$clog2(MS_CYC+1)-1:0] div_r;
	logic ms_tick;
	logic epm_on;
	logic apd_evt;
	logic wake_evt;
	// shared blink phase
	logic [7:0] blink_cnt_r;
	logic blink_ph_r;

	// write happens at the edge where ack is sampled high
	assign wr_now = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
	// current value of the addressed register for byte merge
	always_comb begin
		wr_word = 32'h0000_0000;
		case (wb_adr_i)
			REG_CTRL: wr_word = {30'h0000_0000, ctrl_epm_r, ctrl_pd_r};
			REG_WAKE_INT: wr_word = {16'h0000, wake_int_r};
			REG_LED_MODE: wr_word = {16'h0000, led_mode_r};
			REG_LED_BEHAV: wr_word = {24'h00_0000, led_behav_r};
			REG_EEE_CTRL: wr_word = {31'h0000_0000, invert_r};
			REG_IRQ_MASK: wr_word = {29'h0000_0000, irq_mask_r};
			default: wr_word = 32'h0000_0000;
		endcase
	end
	// enabled lanes take the write data, the others keep the register
	assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wr_merged = (wr_word & ~lane_mask) | (wb_dat_i & lane_mask);

	// wishbone ack: one wait state, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
		end
	end

	// read data captured in the cycle before ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_r <= 32'h0000_0000;
		end else if (wb_cyc_i & wb_stb_i & ~ack_r) begin
			case (wb_adr_i)
				REG_STATUS: rdat_r <= {28'h000_0000, sd_r, epm_r, phy_power_down_o};
				REG_CABLE: rdat_r <= {21'h00_0000, cable_unrel_r, cable_valid_r,
					cable_fault_r, cable_m_r};
				REG_IRQ_STAT: rdat_r <= {29'h0000_0000, irq_stat_r};
				default: rdat_r <= wr_word; // writable registers read back, unmapped reads as zero
			endcase
		end
	end
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	// control register: power-down and enhanced enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_pd_r <= 1'b0;
			ctrl_epm_r <= 1'b0;
		end else if (wr_now && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
			ctrl_pd_r <= wb_dat_i[CTRL_PD_BIT];
			ctrl_epm_r <= wb_dat_i[CTRL_EPM_BIT]; // takes effect at once
		end
	end

	// wake interval and interrupt mask
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_int_r <= WAKE_INT_RST;
			irq_mask_r <= '0;
		end else if (wr_now) begin
			if (wb_adr_i == REG_WAKE_INT) begin
				wake_int_r <= wr_merged[15:0];
			end
			if (wb_adr_i == REG_IRQ_MASK) begin
				irq_mask_r <= wr_merged[IRQ_BITS-1:0];
			end
		end
	end

	// light configuration: software write or nonvolatile load
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			led_mode_r <= LED_MODE_RST;
			led_behav_r <= LED_BEHAV_RST;
			invert_r <= 1'b0; // active low after reset
			nv_wake_dflt_r <= 1'b0;
		end else if (wr_now) begin
			// software write wins over a simultaneous load
			if (wb_adr_i == REG_LED_MODE) begin
				led_mode_r <= wr_merged[15:0];
			end
			if (wb_adr_i == REG_LED_BEHAV) begin
				led_behav_r <= wr_merged[7:0];
			end
			if (wb_adr_i == REG_EEE_CTRL && wb_sel_i[0]) begin
				invert_r <= wb_dat_i[0];
			end
		end else if (nv_i.load) begin
			// entries 0..3 give modes, entry 4 behaviour and defaults
			led_mode_r <= {nv_i.entry[3][3:0], nv_i.entry[2][3:0],
				nv_i.entry[1][3:0], nv_i.entry[0][3:0]};
			led_behav_r <= {4'h0, nv_i.entry[4][3:0]};
			invert_r <= nv_i.entry[4][4];
			nv_wake_dflt_r <= nv_i.entry[4][5];
		end
	end

	// cable diagnostic result capture
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cable_m_r <= 8'h00;
			cable_fault_r <= 1'b0;
			cable_valid_r <= 1'b0;
			cable_unrel_r <= 1'b0;
		end else if (diag_i.done) begin
			if (diag_i.fault) begin
				cable_m_r <= diag_i.dist_m; // distance to the fault
				cable_fault_r <= 1'b1;
				cable_valid_r <= 1'b1;
			end else if (diag_i.terminated) begin
				cable_m_r <= diag_i.dist_m; // full length in meters
				cable_fault_r <= 1'b0;
				cable_valid_r <= 1'b1;
			end else begin
				// anomalous termination: no length to give
				cable_fault_r <= 1'b0;
				cable_valid_r <= 1'b0;
			end
			cable_unrel_r <= (diag_i.dist_m > CABLE_MAX_M);
		end
	end

	// signal detect passes two flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sd_meta_r <= 1'b0;
			sd_r <= 1'b0;
		end else begin
			sd_meta_r <= signal_detect_i;
			sd_r <= sd_meta_r;
		end
	end

	// millisecond enable divider
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_r <= '0;
		end else if (ms_tick) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end
	assign ms_tick = (div_r == ($bits(div_r))'(MS_CYC - 1));

	// enhanced mode enabled by software or by nonvolatile default in wake state
	assign epm_on = (ctrl_epm_r | (nv_wake_dflt_r & (suspend_i == SUSP_WAKE)))
		& (suspend_i != SUSP_DEEPEST);
	assign apd_evt = (epm_r == EPM_ACTIVE) & epm_on & ~sd_r & ms_tick & (ms_cnt_r >= QUIET_MS);
	assign wake_evt = (epm_r != EPM_ACTIVE) & epm_on & sd_r;

	// enhanced power machine
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			epm_r <= EPM_ACTIVE;
			ms_cnt_r <= 16'h0000;
		end else if (!epm_on) begin
			epm_r <= EPM_ACTIVE;
			ms_cnt_r <= 16'h0000;
		end else begin
			case (epm_r)
				EPM_ACTIVE: begin
					if (sd_r) begin
						ms_cnt_r <= 16'h0000;
					end else if (apd_evt) begin
						epm_r <= EPM_SLEEP; // no link presence seen
						ms_cnt_r <= 16'h0000;
					end else if (ms_tick) begin
						ms_cnt_r <= ms_cnt_r + 16'h0001;
					end
				end
				EPM_SLEEP: begin
					if (sd_r) begin
						epm_r <= EPM_ACTIVE;
						ms_cnt_r <= 16'h0000;
					end else if (ms_tick && ms_cnt_r + 16'h0001 >= wake_int_r) begin
						epm_r <= EPM_BURST; // periodic wake
						ms_cnt_r <= 16'h0000;
					end else if (ms_tick) begin
						ms_cnt_r <= ms_cnt_r + 16'h0001;
					end
				end
				EPM_BURST: begin
					if (sd_r) begin
						epm_r <= EPM_ACTIVE;
						ms_cnt_r <= 16'h0000;
					end else if (ms_tick && ms_cnt_r + 16'h0001 >= BURST_MS) begin
						epm_r <= EPM_SLEEP; // burst over, sleep again
						ms_cnt_r <= 16'h0000;
					end else if (ms_tick) begin
						ms_cnt_r <= ms_cnt_r + 16'h0001;
					end
				end
				default: begin
					epm_r <= EPM_ACTIVE;
					ms_cnt_r <= 16'h0000;
				end
			endcase
		end
	end

	// power-down and pulse burst outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phy_power_down_o <= 1'b0;
			flp_burst_o <= 1'b0;
		end else begin
			phy_power_down_o <= ctrl_pd_r
				| (epm_r == EPM_SLEEP)
				| (suspend_i == SUSP_DEEPEST); // phy disabled
			flp_burst_o <= (epm_r == EPM_BURST);
		end
	end

	// events of this cycle, placed at their status bits
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_DIAG_BIT] = diag_i.done;
		irq_set[IRQ_APD_BIT] = apd_evt;
		irq_set[IRQ_WAKE_BIT] = wake_evt;
	end
	assign irq_clr = (wr_now && wb_adr_i == REG_IRQ_STAT && wb_sel_i[0]) ?
		wb_dat_i[IRQ_BITS-1:0] : '0;

	// sticky interrupt status, set wins over write-one clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_r <= '0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
		end
	end

	// level interrupt from unmasked status
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_stat_r & irq_mask_r);
		end
	end

	// blink phase toggles every half period
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blink_cnt_r <= 8'h00;
			blink_ph_r <= 1'b0;
		end else if (ms_tick) begin
			if (blink_cnt_r + 8'h01 >= BLINK_HALF_MS) begin
				blink_cnt_r <= 8'h00;
				blink_ph_r <= ~blink_ph_r;
			end else begin
				blink_cnt_r <= blink_cnt_r + 8'h01;
			end
		end
	end

	// one decoder per status light
	for (genvar g = 0; g < LEDS; g++) begin : g_led
		logic [7:0] hold_r; // activity stretch timer in ms
		logic [3:0] mode;
		logic link_ok;
		logic raw;

		// activity stretch timer, reloaded on every activity
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				hold_r <= 8'h00;
			end else if (link_i.activity) begin
				hold_r <= STRETCH_MS;
			end else if (ms_tick && hold_r != 8'h00) begin
				hold_r <= hold_r - 8'h01;
			end
		end

		// mode decode to the uninverted level
		always_comb begin
			mode = led_mode_r[(g%4)*4 +: 4]; // own field
			case (mode)
				LED_M_LINK_ANY: link_ok = link_i.up; // any speed
				LED_M_LINK_1000: link_ok = link_i.up & (link_i.speed == SPD_1000);
				LED_M_LINK_100: link_ok = link_i.up & (link_i.speed == SPD_100);
				LED_M_LINK_10: link_ok = link_i.up & (link_i.speed == SPD_10);
				LED_M_LINK_HI: link_ok = link_i.up & (link_i.speed != SPD_10);
				default: link_ok = 1'b0;
			endcase
			if (!link_ok) begin
				raw = 1'b1; // no link
			end else if (hold_r != 8'h00 && !led_behav_r[4 + (g%4)]) begin
				// activity: stretch holds off, blink toggles
				raw = led_behav_r[g%4] ? 1'b1 : blink_ph_r;
			end else begin
				raw = 1'b0; // valid link
			end
		end

		// registered light output, inverted after decode
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				status_light_outputs_o[g] <= 1'b1;
			end else begin
				status_light_outputs_o[g] <= raw ^ invert_r;
			end
		end
	end
endmodule
`default_nettype wire

// ### bench/ppl_top_assertions.sv
// checker: concurrent assertions on the ports of the power and light block
`default_nettype none
module ppl_chk
	import ppl_pkg::*;
#(
	parameter int MS_CYC = 4,
	parameter int LEDS = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus handshake
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// media side and power
	input wire logic signal_detect_i,
	input wire ppl_susp_type suspend_i,
	input wire logic phy_power_down_o,
	input wire logic flp_burst_o,
	// lights and interrupt
	input wire logic [LEDS-1:0] status_light_outputs_o,
	input wire logic irq_o
);
	// longest wake burst plus register slack
	localparam int BMAX = 2 * MS_CYC + 4;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// a taken request is answered on the next edge
	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	// the answer is a single cycle pulse
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus answer longer than one cycle");
	// no answer without a request
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("bus answer without request");
	// lights off and power outputs idle right after reset
	AST_RST_QUIET: assert property ($past(rst_i) |-> (&status_light_outputs_o)
		&& !irq_o && !flp_burst_o && !phy_power_down_o)
		else $error("outputs not at reset levels");
	// deepest suspend always powers down
	AST_DEEP_DOWN: assert property (suspend_i == SUSP_DEEPEST [*3] |-> phy_power_down_o)
		else $error("deepest suspend without power down");
	// deepest suspend sends no wake bursts
	AST_DEEP_NOBURST: assert property (suspend_i == SUSP_DEEPEST [*3] |-> !flp_burst_o)
		else $error("wake burst in deepest suspend");
	// a present signal stops the wake bursts
	AST_SD_AWAKE: assert property (signal_detect_i [*6] |-> !flp_burst_o)
		else $error("wake burst while signal present");
	// a wake burst ends within its length
	AST_BURST_END: assert property ($rose(flp_burst_o) |-> ##[1:BMAX] !flp_burst_o)
		else $error("wake burst too long");
	// main scenarios reached
	cover property ($rose(flp_burst_o));
	cover property ($rose(phy_power_down_o));
	cover property ($rose(irq_o));
endmodule
bind ppl_top ppl_chk #(.MS_CYC(MS_CYC), .LEDS(LEDS)) u_chk (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .signal_detect_i, .suspend_i, .phy_power_down_o, .flp_burst_o,
	.status_light_outputs_o, .irq_o);
`default_nettype wire

// ### bench/ppl_partner.sv
// partner: remote link partner phy at the far end of the cable
`default_nettype none
module ppl_partner
	import ppl_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// scenario controls
	input wire logic present_i,
	input wire logic sleepy_i,
	input wire logic act_i,
	// burst from the local phy
	input wire logic flp_burst_i,
	// what the local phy sees
	output logic signal_detect_o,
	output var ppl_link_type link_o
);
	logic awake_r; // partner powered and sending pulses
	logic burst_r; // last burst level, to see its end
	// a sleepy partner only starts once a whole burst has reached it
	always_ff @(posedge clk_i) begin
		burst_r <= flp_burst_i;
		if (rst_i || !present_i) begin
			awake_r <= 1'b0;
		end else if (!sleepy_i || (burst_r && !flp_burst_i)) begin
			awake_r <= 1'b1;
		end
	end
	// pulses show as signal detect; an absent partner sends nothing
	assign signal_detect_o = awake_r;
	assign link_o = {awake_r, SPD_1000, awake_r & act_i};
endmodule
`default_nettype wire

// ### bench/phy_power_and_led_status_tb.sv
// testbench: bus, cable, light and power scenarios for the block
`default_nettype none
module phy_power_and_led_status_tb;
	import ppl_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int MSC = 4; // cycles per ms in simulation
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0000_0000;
	logic [31:0] rdat;
	logic ack, pd, fb, irq, sd;
	logic [3:0] ls;
	logic [2:0] ob; // watched outputs by index
	ppl_link_type lnk;
	ppl_diag_type diag = '0;
	ppl_susp_type susp = SUSP_NORMAL;
	ppl_nv_type nv = '0;
	logic present = 1'b0, sleepy = 1'b0, act = 1'b0;
	int fail_count = 0, compares = 0;
	// diagnostic inputs {terminated, fault, meters} and expected results
	logic [9:0] di [3] = '{10'h264, 10'h132, 10'h282};
	logic [10:0] de [3] = '{11'h264, 11'h332, 11'h682};
	assign ob = {irq, fb, pd};
	// clock
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	ppl_top #(.MS_CYC(MSC)) DUT (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .signal_detect_i(sd), .link_i(lnk), .diag_i(diag),
		.suspend_i(susp), .nv_i(nv), .phy_power_down_o(pd), .flp_burst_o(fb),
		.status_light_outputs_o(ls), .irq_o(irq));
	ppl_partner u_lp (.clk_i, .rst_i, .present_i(present), .sleepy_i(sleepy), .act_i(act),
		.flp_burst_i(fb), .signal_detect_o(sd), .link_o(lnk));
	// compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, s, e);
		end
	endtask
	task automatic cb(input logic s, input logic e);
		chk({31'h0, s}, {31'h0, e});
	endtask
	// one classic bus cycle, held until ack
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		cb(ack, 1'b1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q & m, e);
	endtask
	// bounded wait for a watched output level
	task automatic wt(input int k, input logic v, input int lim);
		int n;
		n = 0;
		while (ob[k] !== v && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		cb(ob[k], v);
	endtask
	task automatic lc(input logic [3:0] e);
		chk({28'h0, ls}, {28'h0, e});
	endtask
	// verdict and end of run
	task automatic results();
		if (fail_count == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		results();
	end
	// main sequence
	initial begin
		int h, n;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(REG_WAKE_INT, 32'h0000_FFFF, 32'h0000_03E8);
		rd(REG_LED_MODE, 32'h0000_FFFF, 32'h0000_4320);
		rd(8'h24, 32'hFFFF_FFFF, 32'h0000_0000);
		lc(4'hF);
		// standard power-down bit
		wr(REG_CTRL, 32'h0000_0001);
		repeat (2) @(posedge clk_i);
		cb(pd, 1'b1);
		rd(REG_STATUS, 32'h0000_0001, 32'h0000_0001);
		wr(REG_CTRL, 32'h0000_0000);
		repeat (2) @(posedge clk_i);
		cb(pd, 1'b0);
		// link at 1000 and polarity
		present <= 1'b1;
		repeat (4) @(posedge clk_i);
		lc(4'h6);
		wr(REG_EEE_CTRL, 32'h0000_0001);
		repeat (2) @(posedge clk_i);
		lc(4'h9);
		wr(REG_EEE_CTRL, 32'h0000_0000);
		// stretched activity on lights 0 and 3
		wr(REG_LED_BEHAV, 32'h0000_0009);
		act <= 1'b1;
		@(posedge clk_i);
		act <= 1'b0;
		repeat (4) @(posedge clk_i);
		lc(4'hF);
		repeat (100 * MSC + 20) @(posedge clk_i);
		lc(4'h6);
		// blinking activity
		wr(REG_LED_BEHAV, 32'h0000_0000);
		act <= 1'b1;
		h = 0;
		repeat (400) begin
			@(posedge clk_i);
			h += int'(ls[0]);
		end
		cb(h > 0 && h < 400, 1'b1);
		act <= 1'b0;
		repeat (100 * MSC + 20) @(posedge clk_i);
		// nonvolatile light and power defaults
		nv <= {1'b1, 8'h30, 8'h03, 8'h02, 8'h02, 8'h01};
		@(posedge clk_i);
		nv.load <= 1'b0;
		rd(REG_LED_MODE, 32'h0000_FFFF, 32'h0000_3221);
		rd(REG_EEE_CTRL, 32'h0000_0001, 32'h0000_0001);
		lc(4'h1);
		// cable results, diag interrupt masked
		wr(REG_IRQ_MASK, 32'h0000_0002);
		for (int i = 0; i < 3; i++) begin
			diag <= {1'b1, di[i]};
			@(posedge clk_i);
			diag.done <= 1'b0;
			rd(REG_CABLE, 32'h0000_07FF, {21'h0, de[i]});
		end
		diag <= {1'b1, 10'h032};
		@(posedge clk_i);
		diag.done <= 1'b0;
		rd(REG_CABLE, 32'h0000_0200, 32'h0000_0000);
		cb(irq, 1'b0);
		rd(REG_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
		wr(REG_IRQ_STAT, 32'h0000_0001);
		// enhanced mode: auto power-down and wake bursts
		present <= 1'b0;
		wr(REG_WAKE_INT, 32'h0000_0003);
		wr(REG_CTRL, 32'h0000_0002);
		wt(0, 1'b1, 1000 * MSC + 50);
		wt(2, 1'b1, 4);
		rd(REG_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
		wt(1, 1'b1, 3 * MSC + 20);
		n = 0;
		while (fb === 1'b1 && n < 40) begin
			@(posedge clk_i);
			n++;
		end
		cb(n >= MSC && n <= 2 * MSC + 1, 1'b1);
		wr(REG_IRQ_STAT, 32'h0000_0002);
		repeat (2) @(posedge clk_i);
		cb(irq, 1'b0);
		present <= 1'b1;
		sleepy <= 1'b1;
		wt(1, 1'b1, 3 * MSC + 20);
		wt(1, 1'b0, 2 * MSC + 8);
		repeat (8) @(posedge clk_i);
		cb(pd, 1'b0);
		rd(REG_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
		// wake event mode uses the stored default
		present <= 1'b0;
		wr(REG_CTRL, 32'h0000_0000);
		repeat (3) @(posedge clk_i);
		cb(pd, 1'b0);
		susp <= SUSP_WAKE;
		wt(0, 1'b1, 1000 * MSC + 50);
		susp <= SUSP_DEEPEST;
		repeat (3) @(posedge clk_i);
		cb(pd, 1'b1);
		rd(REG_STATUS, 32'h0000_0006, 32'h0000_0000);
		susp <= SUSP_NORMAL;
		repeat (4) @(posedge clk_i);
		cb(pd, 1'b0);
		results();
	end
endmodule
`default_nettype wire
